// file: rtl/adt_pkg.sv
// Package with the register map, field layout, reset values and timing of the data bank.
package adt_pkg;

	// Avalon-MM geometry: byte address, one 32-bit word per register.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IDX_W  = 6;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_AUX_R_LO  = 6'h10;
	localparam logic [IDX_W-1:0] IDX_AUX_R_HI  = 6'h11;
	localparam logic [IDX_W-1:0] IDX_ACC_X_LO  = 6'h12;
	localparam logic [IDX_W-1:0] IDX_ACC_X_HI  = 6'h13;
	localparam logic [IDX_W-1:0] IDX_ACC_Y_LO  = 6'h14;
	localparam logic [IDX_W-1:0] IDX_ACC_Y_HI  = 6'h15;
	localparam logic [IDX_W-1:0] IDX_ACC_Z_LO  = 6'h16;
	localparam logic [IDX_W-1:0] IDX_ACC_Z_HI  = 6'h17;
	localparam logic [IDX_W-1:0] IDX_TIME_B0   = 6'h18;
	localparam logic [IDX_W-1:0] IDX_TIME_B1   = 6'h19;
	localparam logic [IDX_W-1:0] IDX_TIME_B2   = 6'h1a;
	localparam logic [IDX_W-1:0] IDX_EVENT     = 6'h1b;
	localparam logic [IDX_W-1:0] IDX_DRDY_STAT = 6'h30;
	localparam logic [IDX_W-1:0] IDX_INT_STAT  = 6'h31;
	localparam logic [IDX_W-1:0] IDX_INT_CLR   = 6'h32;
	localparam logic [IDX_W-1:0] IDX_INT_EN    = 6'h33;
	localparam logic [IDX_W-1:0] IDX_CMD       = 6'h34;

	// Field positions.
	localparam int SAMPLE_W     = 12;
	localparam int LOW_NIB_POS  = 4;
	localparam int TIME_W       = 24;
	localparam int EV_POR_BIT   = 0;
	localparam int DRDY_ACC_BIT = 0;
	localparam int DRDY_AUX_BIT = 1;
	localparam int CMD_SRST_BIT = 0;
	localparam int INT_W        = 3;
	localparam int INT_POR_BIT  = 0;
	localparam int INT_ACC_BIT  = 1;
	localparam int INT_AUX_BIT  = 2;

	// Values after reset.
	localparam logic [7:0]          EVENT_RST   = 8'h01;
	localparam logic [7:0]          DATA_RST    = 8'h00;
	localparam logic [INT_W-1:0]    INT_EN_RST  = 3'h0;
	localparam logic [INT_W-1:0]    INT_ST_RST  = 3'h1;

	// Sensor-time tick: 39.0625 us, kept in picoseconds so a phase accumulator stays exact.
	localparam longint TICK_PS      = 64'd39062500;
	localparam longint CLK_PS       = 64'd10000;
	localparam int     PHASE_W      = 26;
	localparam logic [PHASE_W-1:0] PHASE_TICK = PHASE_W'(TICK_PS);
	localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(CLK_PS);
	// Whole clock cycles in one tick, rounded down, for reference by checks.
	localparam int     TICK_CYCLES  = int'(TICK_PS / CLK_PS);

	// Bus handshake states.
	typedef enum logic [0:0] {
		ADT_IDLE = 1'b0,
		ADT_ACK  = 1'b1
	} adt_bus_type;

endpackage : adt_pkg

// file: rtl/adt_regs.sv
// Read-only data, sensor-time and power-event register bank behind an Avalon-MM slave.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps

// Contract
// - Aux R sample split, low nibble reserved
// - X sample split, low nibble reserved
// - Y sample split, low nibble reserved
// - Z sample split, low nibble reserved
// - Time byte 0, 39.0625 us per count
// - Time byte 1, 10 ms per count
// - Time byte 2, 2.56 s per count
// - Power-on flag set after reset, soft reset
// - Reading event register returns then clears flag
// - Event register resets to 0x01, rest zero
// - Data and time registers read-only, reset zero
// - Reading accel byte clears accel data-ready
// - Reading aux byte clears aux data-ready
module adt_regs (
	// Clock and reset.
	input  wire logic                          clk_sys,
	input  wire logic                          rstn,
	// Avalon-MM slave.
	input  wire logic [adt_pkg::ADDR_W-1:0]    avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [adt_pkg::DATA_W-1:0]    avs_writedata,
	output logic      [adt_pkg::DATA_W-1:0]    avs_readdata,
	output logic                               avs_waitrequest,
	// Accelerometer sample input.
	input  wire logic                          acc_valid,
	input  wire logic [adt_pkg::SAMPLE_W-1:0]  acc_x,
	input  wire logic [adt_pkg::SAMPLE_W-1:0]  acc_y,
	input  wire logic [adt_pkg::SAMPLE_W-1:0]  acc_z,
	// Auxiliary R sample input.
	input  wire logic                          aux_valid,
	input  wire logic [adt_pkg::SAMPLE_W-1:0]  aux_r,
	// Status outputs.
	output logic                               irq,
	output logic [adt_pkg::TIME_W-1:0]         sensor_time
);
	import adt_pkg::*;

	// All state of the bank in one record.
	typedef struct packed {
		adt_bus_type          bus;       // Handshake phase.
		logic [DATA_W-1:0]    rdata;     // Registered read data.
		logic [SAMPLE_W-1:0]  aux_r;     // Latched aux R sample.
		logic [SAMPLE_W-1:0]  acc_x;     // Latched X sample.
		logic [SAMPLE_W-1:0]  acc_y;     // Latched Y sample.
		logic [SAMPLE_W-1:0]  acc_z;     // Latched Z sample.
		logic [TIME_W-1:0]    stime;     // Sensor-time counter.
		logic [PHASE_W-1:0]   phase;     // Picosecond phase toward the next tick.
		logic                 por;       // Power-on-detected flag.
		logic                 drdy_acc;  // Accelerometer data ready.
		logic                 drdy_aux;  // Auxiliary data ready.
		logic [INT_W-1:0]     int_stat;  // Sticky interrupt status.
		logic [INT_W-1:0]     int_en;    // Interrupt enables.
	} adt_state_type;

	adt_state_type q;   // Registered state.
	adt_state_type d;   // Next state.

	logic [IDX_W-1:0] idx;        // Register index from the byte address.
	logic             aligned;    // Address is word aligned.
	logic             req;        // A request is on the bus.
	logic             accept;     // The request completes at this edge.
	logic             rd_acc;     // A read completes at this edge.
	logic             wr_acc;     // A write completes at this edge.
	logic             soft_rst;   // Soft reset command completes at this edge.
	logic             tick;       // One sensor-time tick elapses at this edge.
	logic [PHASE_W-1:0] phase_sum; // Phase after this cycle's step.
	logic [INT_W-1:0] int_ev;     // Events seen this cycle.
	logic [INT_W-1:0] int_clr;    // Status bits cleared by software this cycle.

	// Address decode and the handshake: every access takes exactly one wait cycle.
	assign idx             = avs_address[ADDR_W-1:2];
	assign aligned         = (avs_address[1:0] == 2'h0);
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & (q.bus != ADT_ACK);
	assign accept          = req & (q.bus == ADT_ACK);
	assign rd_acc          = accept & avs_read;
	assign wr_acc          = accept & avs_write;
	assign soft_rst        = wr_acc & aligned & (idx == IDX_CMD) & avs_writedata[CMD_SRST_BIT];
	assign avs_readdata    = q.rdata;
	assign sensor_time     = q.stime;
	assign irq             = |(q.int_stat & q.int_en);

	// Read multiplexer; reserved bits and unmapped addresses return zero.
	function automatic logic [DATA_W-1:0] read_word(input adt_state_type s,
	                                                input logic [IDX_W-1:0] i);
		logic [DATA_W-1:0] w;
		w = '0;
		case (i)
			IDX_AUX_R_LO:  w[7:0] = {s.aux_r[3:0], 4'h0};
			IDX_AUX_R_HI:  w[7:0] = s.aux_r[11:4];
			IDX_ACC_X_LO:  w[7:0] = {s.acc_x[3:0], 4'h0};
			IDX_ACC_X_HI:  w[7:0] = s.acc_x[11:4];
			IDX_ACC_Y_LO:  w[7:0] = {s.acc_y[3:0], 4'h0};
			IDX_ACC_Y_HI:  w[7:0] = s.acc_y[11:4];
			IDX_ACC_Z_LO:  w[7:0] = {s.acc_z[3:0], 4'h0};
			IDX_ACC_Z_HI:  w[7:0] = s.acc_z[11:4];
			IDX_TIME_B0:   w[7:0] = s.stime[7:0];
			IDX_TIME_B1:   w[7:0] = s.stime[15:8];
			IDX_TIME_B2:   w[7:0] = s.stime[23:16];
			IDX_EVENT:     w[EV_POR_BIT] = s.por;
			IDX_DRDY_STAT: begin
				w[DRDY_ACC_BIT] = s.drdy_acc;
				w[DRDY_AUX_BIT] = s.drdy_aux;
			end
			IDX_INT_STAT:  w[INT_W-1:0] = s.int_stat;
			IDX_INT_EN:    w[INT_W-1:0] = s.int_en;
			default:       w = '0;
		endcase
		return w;
	endfunction

	// Phase accumulator: exact 39.0625 us ticks from the 10 ns clock.
	always_comb begin
		phase_sum = q.phase + PHASE_STEP;
		tick      = (phase_sum >= PHASE_TICK);
	end

	// Next-state logic for the whole bank.
	always_comb begin
		d       = q;
		int_ev  = '0;
		int_clr = '0;

		// Bus phase: acknowledge one cycle after a request appears.
		if (req && (q.bus == ADT_IDLE)) begin
			d.bus = ADT_ACK;
		end else begin
			d.bus = ADT_IDLE;
		end

		// Read data is captured during the wait cycle and stands at the accepting edge.
		if (req && (q.bus == ADT_IDLE) && avs_read) begin
			d.rdata = aligned ? read_word(q, idx) : '0;
		end

		// Sensor time counts every tick and wraps naturally at its width.
		if (tick) begin
			d.phase = phase_sum - PHASE_TICK;
			d.stime = q.stime + TIME_W'(1);
		end else begin
			d.phase = phase_sum;
		end

		// Clear-on-read side effects, applied when the read completes.
		if (rd_acc && aligned) begin
			if (idx == IDX_EVENT) begin
				d.por = 1'b0;
			end
			if ((idx == IDX_AUX_R_LO) || (idx == IDX_AUX_R_HI)) begin
				d.drdy_aux = 1'b0;
			end
			if ((idx >= IDX_ACC_X_LO) && (idx <= IDX_ACC_Z_HI)) begin
				d.drdy_acc = 1'b0;
			end
		end

		// Software writes: enables and write-one-to-clear status.
		if (wr_acc && aligned) begin
			if (idx == IDX_INT_EN) begin
				d.int_en = avs_writedata[INT_W-1:0];
			end
			if (idx == IDX_INT_CLR) begin
				int_clr = avs_writedata[INT_W-1:0];
			end
		end

		// New samples latch and raise data ready; a new sample beats a clearing read.
		if (acc_valid) begin
			d.acc_x    = acc_x;
			d.acc_y    = acc_y;
			d.acc_z    = acc_z;
			d.drdy_acc = 1'b1;
			int_ev[INT_ACC_BIT] = 1'b1;
		end
		if (aux_valid) begin
			d.aux_r    = aux_r;
			d.drdy_aux = 1'b1;
			int_ev[INT_AUX_BIT] = 1'b1;
		end

		// Soft reset returns data and time to zero and raises the power-on flag.
		if (soft_rst) begin
			d.aux_r    = '0;
			d.acc_x    = '0;
			d.acc_y    = '0;
			d.acc_z    = '0;
			d.stime    = '0;
			d.phase    = '0;
			d.drdy_acc = 1'b0;
			d.drdy_aux = 1'b0;
			d.por      = 1'b1;
			int_ev     = '0;
			int_ev[INT_POR_BIT] = 1'b1;
		end

		// Sticky status: a set in the same cycle as its clear wins.
		d.int_stat = (q.int_stat & ~int_clr) | int_ev;
	end

	// State register; power-on state has the event flag raised.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q          <= '0;
			q.bus      <= ADT_IDLE;
			q.por      <= EVENT_RST[EV_POR_BIT];
			q.int_stat <= INT_ST_RST;
			q.int_en   <= INT_EN_RST;
		end else begin
			q <= d;
		end
	end

	// Checks on the bank's behaviour.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_bus_wait_bound: assert property (
		req && (q.bus == ADT_IDLE) |-> avs_waitrequest ##1 (!avs_waitrequest || !req))
		else $error("Bus access did not complete after one wait cycle.");

	a_aux_r_low: assert property (
		rd_acc && aligned && (idx == IDX_AUX_R_LO) && $stable(q.aux_r)
		|-> avs_readdata == {24'h0, q.aux_r[3:0], 4'h0})
		else $error("Aux R low byte layout wrong.");

	a_x_low_layout: assert property (
		rd_acc && aligned && (idx == IDX_ACC_X_LO) |-> avs_readdata[3:0] == 4'h0
		&& avs_readdata[31:8] == 24'h0)
		else $error("X low byte reserved bits not zero.");

	a_y_high_byte: assert property (
		rd_acc && aligned && (idx == IDX_ACC_Y_HI) && $stable(q.acc_y)
		|-> avs_readdata == {24'h0, q.acc_y[11:4]})
		else $error("Y high byte does not hold sample bits 11 to 4.");

	a_z_sample_latch: assert property (
		acc_valid && !soft_rst |=> q.acc_z == $past(acc_z))
		else $error("Z sample was not latched.");

	a_time_tick: assert property (
		tick && !soft_rst |=> q.stime == $past(q.stime) + 24'h1)
		else $error("Sensor time did not advance on a tick.");

	a_time_hold: assert property (
		!tick && !soft_rst |=> $stable(q.stime))
		else $error("Sensor time moved without a tick.");

	a_tick_spacing: assert property (
		tick |=> !tick [*8])
		else $error("Sensor-time ticks came too close together.");

	a_por_soft_set: assert property (
		soft_rst |=> q.por && q.int_stat[INT_POR_BIT])
		else $error("Soft reset did not raise the power-on flag.");

	a_por_read_clear: assert property (
		rd_acc && aligned && (idx == IDX_EVENT) && !soft_rst
		|-> avs_readdata == {31'h0, q.por} ##1 !q.por)
		else $error("Event read did not return and clear the flag.");

	a_acc_drdy_clear: assert property (
		rd_acc && aligned && (idx >= IDX_ACC_X_LO) && (idx <= IDX_ACC_Z_HI)
		&& !acc_valid |=> !q.drdy_acc)
		else $error("Accel data ready not cleared by data read.");

	a_aux_drdy_clear: assert property (
		rd_acc && aligned && (idx == IDX_AUX_R_HI) && !aux_valid |=> !q.drdy_aux)
		else $error("Aux data ready not cleared by data read.");

	a_irq_level: assert property (
		$rose(irq) |-> ($past(int_ev) != 3'h0) || $past(wr_acc))
		else $error("Interrupt rose without an event or enable write.");

	// The aux R high byte carries the upper eight sample bits.
	a_aux_r_high: assert property (
		rd_acc && aligned && (idx == IDX_AUX_R_HI) && $stable(q.aux_r)
		|-> avs_readdata == {24'h0, q.aux_r[11:4]})
		else $error("Aux R high byte does not hold sample bits 11 to 4.");

	// The X high byte carries the upper eight sample bits.
	a_x_high_byte: assert property (
		rd_acc && aligned && (idx == IDX_ACC_X_HI) && $stable(q.acc_x)
		|-> avs_readdata == {24'h0, q.acc_x[11:4]})
		else $error("X high byte does not hold sample bits 11 to 4.");

	// The Y low byte carries the low nibble on top of a zero nibble.
	a_y_low_byte: assert property (
		rd_acc && aligned && (idx == IDX_ACC_Y_LO) && $stable(q.acc_y)
		|-> avs_readdata == {24'h0, q.acc_y[3:0], 4'h0})
		else $error("Y low byte layout wrong.");

	// The Z low byte carries the low nibble on top of a zero nibble.
	a_z_low_byte: assert property (
		rd_acc && aligned && (idx == IDX_ACC_Z_LO) && $stable(q.acc_z)
		|-> avs_readdata == {24'h0, q.acc_z[3:0], 4'h0})
		else $error("Z low byte layout wrong.");

	// The Z high byte carries the upper eight sample bits.
	a_z_high_byte: assert property (
		rd_acc && aligned && (idx == IDX_ACC_Z_HI) && $stable(q.acc_z)
		|-> avs_readdata == {24'h0, q.acc_z[11:4]})
		else $error("Z high byte does not hold sample bits 11 to 4.");

	// Time byte 0 returns counter bits 7 to 0.
	a_time_byte_low: assert property (
		rd_acc && aligned && (idx == IDX_TIME_B0) && $stable(q.stime)
		|-> avs_readdata == {24'h0, q.stime[7:0]})
		else $error("Time byte 0 does not hold counter bits 7 to 0.");

	// Time byte 1 returns counter bits 15 to 8.
	a_time_byte_mid: assert property (
		rd_acc && aligned && (idx == IDX_TIME_B1) && $stable(q.stime)
		|-> avs_readdata == {24'h0, q.stime[15:8]})
		else $error("Time byte 1 does not hold counter bits 15 to 8.");

	// Time byte 2 returns counter bits 23 to 16.
	a_time_byte_top: assert property (
		rd_acc && aligned && (idx == IDX_TIME_B2) && $stable(q.stime)
		|-> avs_readdata == {24'h0, q.stime[23:16]})
		else $error("Time byte 2 does not hold counter bits 23 to 16.");

	// Every event register bit above the flag reads zero.
	a_event_reserved: assert property (
		rd_acc && aligned && (idx == IDX_EVENT)
		|-> avs_readdata[DATA_W-1:1] == 31'h0)
		else $error("Event register reserved bits not zero.");

	// Writes other than a soft reset never reach the sample registers.
	a_data_read_only: assert property (
		wr_acc && !acc_valid && !aux_valid && !soft_rst
		|=> $stable(q.aux_r) && $stable(q.acc_x) && $stable(q.acc_y) && $stable(q.acc_z))
		else $error("A write changed a read-only sample register.");

	// A read of the aux R low byte also drops aux data ready.
	a_aux_low_clear: assert property (
		rd_acc && aligned && (idx == IDX_AUX_R_LO) && !aux_valid
		|=> !q.drdy_aux)
		else $error("Aux data ready not cleared by low byte read.");

	// Every byte register of the bank has zero above bit 7.
	a_reserved_zero: assert property (
		rd_acc && aligned && (idx >= IDX_AUX_R_LO) && (idx <= IDX_EVENT)
		|-> avs_readdata[DATA_W-1:8] == 24'h0)
		else $error("Upper bits of a byte register not zero.");

	// A sticky accel status bit only drops through the clear register.
	a_stat_sticky: assert property (
		q.int_stat[INT_ACC_BIT] && !(wr_acc && aligned && (idx == IDX_INT_CLR))
		|=> q.int_stat[INT_ACC_BIT])
		else $error("Accel status bit dropped without a clear write.");

	// A new accel sample raises data ready unless a soft reset completes in the same cycle.
	a_drdy_acc_set: assert property (
		acc_valid && !soft_rst
		|=> q.drdy_acc)
		else $error("Accel data ready not raised by a new sample.");

endmodule // adt_regs

// file: sim/adt_host.sv
// Avalon-MM host model that issues single register accesses to the bank.
`timescale 1ns/1ps
module adt_host (
	// Clock.
	input  wire logic                        clk_sys,
	// Avalon-MM master side.
	output logic [adt_pkg::ADDR_W-1:0]       address,
	output logic                             read,
	output logic                             write,
	output logic [adt_pkg::DATA_W-1:0]       writedata,
	input  wire logic [adt_pkg::DATA_W-1:0]  readdata,
	input  wire logic                        waitrequest
);
	import adt_pkg::*;

	int waits = 0;   // Wait cycles seen by the last access.

	// The bus starts idle so nothing is requested during reset.
	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
	end

	// Holds one request until waitrequest is sampled low, then releases it.
	// A bounded wait reports a hang through ok instead of blocking forever.
	task automatic acc(input bit wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output bit ok);
		ok = 1'b0;
		rd = 32'h0;
		@(posedge clk_sys);
		address <= a;
		writedata <= wd;
		read <= !wr;
		write <= wr;
		for (int i = 0; i < 20 && !ok; i++) begin
			@(posedge clk_sys);
			if (waitrequest === 1'b0) begin
				ok = 1'b1;
				rd = readdata;
				waits = i;
			end
		end
		read <= 1'b0;
		write <= 1'b0;
	endtask
endmodule // adt_host

// file: sim/test_accel_data_time_event_regs.sv
// Self-checking bench for the data, sensor-time and power-event register bank.
`timescale 1ns/1ps
module test_accel_data_time_event_regs;
	import adt_pkg::*;
	logic                clk_sys = 1'b0;
	logic                rstn = 1'b0;
	logic [ADDR_W-1:0]   address;
	logic                read, write, waitrequest, irq;
	logic [DATA_W-1:0]   writedata, readdata;
	logic                acc_valid = 1'b0, aux_valid = 1'b0;
	logic [SAMPLE_W-1:0] acc_x = 12'h0, acc_y = 12'h0, acc_z = 12'h0, aux_r = 12'h0;
	logic [TIME_W-1:0]   sensor_time, last_t = 24'h0;
	int                  exp_reg [64];   // Expected register words by index.
	int                  tick_n = 0;     // Sensor-time steps seen since reset.
	int                  gap = 0;        // Cycles since the last step.
	int                  n_mismatch = 0, checks_done = 0;

	// Free-running 100 MHz system clock.
	always #5 clk_sys = ~clk_sys;

	adt_regs dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(address), .avs_read(read),
		.avs_write(write), .avs_writedata(writedata), .avs_readdata(readdata),
		.avs_waitrequest(waitrequest), .acc_valid(acc_valid), .acc_x(acc_x), .acc_y(acc_y),
		.acc_z(acc_z), .aux_valid(aux_valid), .aux_r(aux_r), .irq(irq),
		.sensor_time(sensor_time));
	adt_host host (.clk_sys(clk_sys), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

	// Compares a register or counter value.
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	// Compares a single level.
	task automatic chk_lvl(input logic got, input logic want);
		chk_reg({31'h0, got}, {31'h0, want});
	endtask

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// A wait that ran out counts as a mismatch and ends the run.
	task automatic hang();
		n_mismatch++;
		end_of_test();
	endtask

	// Time bytes come from the step count; everything else from the table.
	function automatic int exp_of(input int i);
		if (i >= 24 && i <= 26) return (tick_n >> (8 * (i - 24))) & 8'hff;
		return exp_reg[i];
	endfunction

	// Reads one register, compares it and applies clear-on-read to the model.
	task automatic rd_chk(input int i);
		logic [31:0] d;
		bit          ok;
		host.acc(1'b0, 8'(i * 4), 32'h0, d, ok);
		if (!ok) hang();
		chk_reg(32'(host.waits), 32'h1);
		chk_reg(d, 32'(exp_of(i)));
		if (i == 27) exp_reg[27] = 0;
		if (i == 16 || i == 17) exp_reg[48] &= ~2;
		if (i >= 18 && i <= 23) exp_reg[48] &= ~1;
	endtask

	// Writes one register and updates the model for clear, enable and soft reset.
	task automatic wr(input int i, input int v);
		logic [31:0] d;
		bit          ok;
		host.acc(1'b1, 8'(i * 4), 32'(v), d, ok);
		if (!ok) hang();
		chk_reg(32'(host.waits), 32'h1);
		if (i == 50) exp_reg[49] &= ~v;
		if (i == 51) exp_reg[51] = v & 7;
		if (i == 52 && v[0]) begin
			for (int k = 16; k < 24; k++) exp_reg[k] = 0;
			exp_reg[48] = 0;
			exp_reg[27] = 1;
			exp_reg[49] |= 1;
			tick_n = 0;
		end
	endtask

	// Presents one random set of samples and records the expected byte split.
	task automatic put_sample();
		logic [11:0] s [4];
		foreach (s[k]) s[k] = 12'($urandom);
		@(posedge clk_sys);
		aux_r <= s[0];
		acc_x <= s[1];
		acc_y <= s[2];
		acc_z <= s[3];
		acc_valid <= 1'b1;
		aux_valid <= 1'b1;
		@(posedge clk_sys);
		acc_valid <= 1'b0;
		aux_valid <= 1'b0;
		foreach (s[k]) begin
			exp_reg[16 + 2 * k] = {s[k][3:0], 4'h0};
			exp_reg[17 + 2 * k] = s[k][11:4];
		end
		exp_reg[48] = 3;
		exp_reg[49] |= 6;
	endtask

	// Checks the interrupt level once the last access has settled.
	task automatic chk_irq();
		@(negedge clk_sys);
		chk_lvl(irq, (exp_reg[49] & exp_reg[51]) != 0);
	endtask

	// Waits, bounded, for the next sensor-time step.
	task automatic wait_tick();
		int t0;
		t0 = tick_n;
		for (int i = 0; i < 5000 && tick_n == t0; i++) @(posedge clk_sys);
		if (tick_n == t0) hang();
	endtask

	// Follows each sensor-time step; a step to zero is a soft reset, not a tick.
	always @(posedge clk_sys) begin
		gap++;
		if (rstn === 1'b1 && sensor_time !== last_t && sensor_time !== 24'h0) begin
			tick_n++;
			chk_reg(32'(sensor_time), 32'(tick_n));
			if (tick_n > 1) chk_lvl(gap inside {TICK_CYCLES, TICK_CYCLES + 1}, 1'b1);
			gap = 0;
		end
		last_t = sensor_time;
	end

	// Main sequence.
	initial begin
		void'($urandom(68));
		exp_reg[27] = 1;
		exp_reg[49] = 1;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int i = 16; i < 28; i++) rd_chk(i);
		rd_chk(49);
		rd_chk(27);
		for (int n = 0; n < 3; n++) begin
			put_sample();
			rd_chk(48);
			for (int i = 23; i >= 16; i--) rd_chk(i);
			rd_chk(48);
		end
		wr(18, 32'hff);
		rd_chk(18);
		rd_chk(63);
		wr(51, 2);
		chk_irq();
		wr(50, 2);
		chk_irq();
		wr(51, 7);
		chk_irq();
		wr(50, 7);
		chk_irq();
		put_sample();
		chk_irq();
		rd_chk(49);
		wr(51, 0);
		chk_irq();
		wait_tick();
		wait_tick();
		for (int i = 24; i < 27; i++) rd_chk(i);
		wr(52, 1);
		for (int i = 16; i < 28; i++) rd_chk(i);
		rd_chk(27);
		end_of_test();
	end
endmodule // test_accel_data_time_event_regs
